// ===== hdl/plh_pkg.sv
/*
 Package for the peer-link header encapsulation block: service header layout,
 reserved source tags, election timing and the register map.
 Assumes a 250 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package plh_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned ELECT_WAIT_MS = 3000;
   localparam longint unsigned ELECT_WAIT_CYC = longint'(ELECT_WAIT_MS) * 1000 * CLK_MHZ;

   // ----------------------------------------------------------------
   // Service header
   // ----------------------------------------------------------------
   localparam logic [3:0] HDR_MD_TYPE = 4'h1;
   localparam logic [7:0] HDR_NEXT_PROTO = 8'h03;
   localparam logic [5:0] HDR_LENGTH = 6'h06;
   localparam logic [7:0] HDR_SVC_INDEX = 8'hff;
   localparam logic [14:0] TAG_EDGE_PORT = 15'h7ffe;
   localparam int unsigned BD_W = 16;
   localparam int unsigned TAG_W = 15;

   // ----------------------------------------------------------------
   // Segments and switches
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CLIENTS = 512;
   localparam int unsigned CID_W = 9;
   localparam int unsigned MAX_SW = 4;
   localparam int unsigned SW_W = 2;

   // ----------------------------------------------------------------
   // Register map (byte addresses, carried as is on the bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_OWN_IP = 8'h08;
   localparam logic [7:0] REG_PEER_IP = 8'h0c;
   localparam logic [7:0] REG_TRIGGER = 8'h10;
   localparam logic [7:0] REG_TAB_ADDR = 8'h14;
   localparam logic [7:0] REG_TAB_DATA = 8'h18;
   localparam logic [7:0] REG_WAIT_LO = 8'h1c;

   localparam int unsigned CTRL_LB_BIT = 0;
   localparam int unsigned CTRL_PEER_UP_BIT = 1;
   localparam int unsigned TRIG_DEPLOY_BIT = 0;
   localparam int unsigned TRIG_ROUTE_BIT = 1;
   localparam int unsigned TAB_SEG_UP_BIT = 0;
   localparam int unsigned TAB_DEPLOYED_BIT = 1;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_WORD = 32'hdead_beef;

   typedef enum logic [1:0] {
      EL_IDLE = 2'b00,
      EL_WAIT = 2'b01,
      EL_ELECT = 2'b10
   } plh_el_t;
endpackage : plh_pkg

// ===== hdl/plh_elect.sv
/*
 Per-VLAN flooder election: picks position (vlan mod count) in the sorted
 list of switch addresses. Combinational; the caller registers the result.
 Assumes at most two switches per segment (own and peer).
*/
`timescale 1ns/1ps
module plh_elect (
   input wire logic [31:0] own_ip,
   input wire logic [31:0] peer_ip,
   input wire logic peer_present,
   input wire logic [11:0] vlan,
   output logic own_is_flooder
);
   import plh_pkg::*;

   logic own_first;
   logic [1:0] count;
   logic pos;

   always_comb begin
      // Sorted list holds own address and, if present, the peer's
      own_first = (own_ip < peer_ip);
      count = peer_present ? 2'd2 : 2'd1;
      pos = (count == 2'd2) ? vlan[0] : 1'b0;
      own_is_flooder = (count == 2'd1) ? 1'b1 : (pos == (own_first ? 1'b0 : 1'b1));
   end
endmodule : plh_elect

// ===== hdl/plh_encap.sv
/*
 Peer-link header encapsulation and flooder election for a clustered
 switch pair. Holds the per-client tables, the election timer, the
 transmit header builder and the receive echo-suppression path.
 Assumes frames arrive one descriptor per cycle from forwarding logic and
 that the peer's control plane reports routes through the register bus.
 Election settings (balancing, peer presence, and the addresses used by the per-VLAN pick) are sampled as a
 sweep begins and held until the next sweep, so a register write alone
 never moves the flooder choice. Triggers that arrive during a sweep are
 kept pending and acted on when it ends; an immediate trigger overrides a
 pending wait. The sweep visits one client per cycle, so a choice can
 take up to two sweeps (1024 cycles) to settle after a burst of triggers.
 The register bus answers in its second cycle; waitrequest is decoded from
 the request so that the first cycle is always held off.
*/
`timescale 1ns/1ps
module plh_encap (
   input wire logic clk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Transmit descriptor from forwarding
   input wire logic tx_valid,
   input wire logic [11:0] tx_vlan,
   input wire logic tx_from_client,
   input wire logic [plh_pkg::CID_W-1:0] tx_client_id,
   input wire logic tx_multi,
   input wire logic tx_to_peer,
   output logic tx_hdr_valid,
   output logic [31:0] tx_hdr_word0,
   output logic [31:0] tx_hdr_word1,
   output logic [31:0] tx_hdr_word2,
   output logic tx_flood_client,
   output logic tx_local_valid,
   // Receive path from the peer link
   input wire logic rx_valid,
   input wire logic rx_hdr_present,
   input wire logic [31:0] rx_hdr_word0,
   input wire logic [31:0] rx_hdr_word2,
   output logic rx_flood_valid,
   output logic [plh_pkg::TAG_W-1:0] rx_suppress_tag,
   output logic rx_suppress_en,
   output logic rx_l2_valid,
   output logic rx_learn_en,
   output logic rx_drop
);
   import plh_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      logic wait_n;
      logic lb_en;
      logic peer_up;
      logic [31:0] own_ip;
      logic [31:0] peer_ip;
      logic [CID_W-1:0] tab_addr;
      logic [NUM_CLIENTS-1:0] seg_up;
      logic [NUM_CLIENTS-1:0] deployed;
      logic [NUM_CLIENTS-1:0] flooder;
      plh_el_t el_state;
      logic [39:0] wait_cnt;
      logic [CID_W-1:0] el_idx;
      logic el_lb;
      logic el_peer_up;
      logic [31:0] el_own_ip;
      logic [31:0] el_peer_ip;
      logic pend_el;
      logic pend_wait;
      logic [31:0] elect_count;
      logic hdr_v;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic flood_cl;
      logic local_v;
      logic rxf_v;
      logic [TAG_W-1:0] rx_tag;
      logic rx_sup;
      logic rx_l2;
      logic rx_drop;
   } plh_state_t;

   plh_state_t st_ff;
   plh_state_t nxt_st;
   logic elect_own;
   logic [31:0] tab_word;

   // Per-VLAN pick for the frame in flight, from the settings held at sweep start
   plh_elect u_elect (
      .own_ip(st_ff.el_own_ip),
      .peer_ip(st_ff.el_peer_ip),
      .peer_present(st_ff.el_peer_up),
      .vlan(tx_vlan),
      .own_is_flooder(elect_own)
   );

   // Per-client table read view
   always_comb begin
      tab_word = RESET_WORD;
      tab_word[TAB_SEG_UP_BIT] = st_ff.seg_up[st_ff.tab_addr];
      tab_word[TAB_DEPLOYED_BIT] = st_ff.deployed[st_ff.tab_addr];
      tab_word[2] = st_ff.flooder[st_ff.tab_addr];
   end

   always_comb begin
      logic acc;
      logic start_wait;
      logic elect_now;
      logic hdr_ok;
      logic vlan_ok;
      logic sw_lb;
      logic sw_peer;
      acc = 1'b0;
      start_wait = 1'b0;
      elect_now = 1'b0;
      hdr_ok = 1'b0;
      vlan_ok = 1'b0;
      sw_lb = 1'b0;
      sw_peer = 1'b0;
      nxt_st = st_ff;

      // ----------------------------------------------------------------
      // Register bus: one wait cycle, answer on the second edge
      // ----------------------------------------------------------------
      acc = (avs_read || avs_write) && !st_ff.wait_n;
      nxt_st.wait_n = acc;
      if (acc && avs_read) begin
         case (avs_address)
            REG_CTRL: nxt_st.rdata = {30'h0000_0000, st_ff.peer_up, st_ff.lb_en};
            REG_STATUS: nxt_st.rdata = {30'h0000_0000, st_ff.el_state};
            REG_OWN_IP: nxt_st.rdata = st_ff.own_ip;
            REG_PEER_IP: nxt_st.rdata = st_ff.peer_ip;
            REG_TAB_ADDR: nxt_st.rdata = {23'h00_0000, st_ff.tab_addr};
            REG_TAB_DATA: nxt_st.rdata = tab_word;
            REG_WAIT_LO: nxt_st.rdata = st_ff.elect_count;
            default: nxt_st.rdata = UNMAPPED_WORD;
         endcase
      end
      if (acc && avs_write) begin
         case (avs_address)
            REG_CTRL: begin
               nxt_st.lb_en = avs_writedata[CTRL_LB_BIT];
               if (st_ff.peer_up != avs_writedata[CTRL_PEER_UP_BIT]) begin
                  elect_now = 1'b1;
               end
               nxt_st.peer_up = avs_writedata[CTRL_PEER_UP_BIT];
            end
            REG_OWN_IP: nxt_st.own_ip = avs_writedata;
            REG_PEER_IP: nxt_st.peer_ip = avs_writedata;
            REG_TAB_ADDR: nxt_st.tab_addr = avs_writedata[CID_W-1:0];
            // Deploying a client starts the wait; a link change elects at once
            REG_TAB_DATA: begin
               if (avs_writedata[TAB_DEPLOYED_BIT] && !st_ff.deployed[st_ff.tab_addr]) begin
                  start_wait = 1'b1;
               end
               if (avs_writedata[TAB_SEG_UP_BIT] != st_ff.seg_up[st_ff.tab_addr]) begin
                  elect_now = 1'b1;
               end
               nxt_st.seg_up[st_ff.tab_addr] = avs_writedata[TAB_SEG_UP_BIT];
               nxt_st.deployed[st_ff.tab_addr] = avs_writedata[TAB_DEPLOYED_BIT];
            end
            REG_TRIGGER: begin
               if (avs_writedata[TRIG_DEPLOY_BIT]) begin
                  start_wait = 1'b1;
               end
               if (avs_writedata[TRIG_ROUTE_BIT]) begin
                  elect_now = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // Sweep settings: taken as a sweep begins, held until the next one
      // ----------------------------------------------------------------
      sw_lb = st_ff.el_lb;
      sw_peer = st_ff.el_peer_up;
      if (st_ff.el_state == EL_ELECT && st_ff.el_idx == '0) begin
         sw_lb = st_ff.lb_en;
         sw_peer = st_ff.peer_up;
         nxt_st.el_lb = st_ff.lb_en;
         nxt_st.el_peer_up = st_ff.peer_up;
         nxt_st.el_own_ip = st_ff.own_ip;
         nxt_st.el_peer_ip = st_ff.peer_ip;
      end

      // ----------------------------------------------------------------
      // Election sequencer: one client per cycle over all 512 entries
      // ----------------------------------------------------------------
      case (st_ff.el_state)
         EL_IDLE: begin
            // Deployment wins over an immediate trigger in the same write
            if (start_wait) begin
               nxt_st.el_state = EL_WAIT;
               nxt_st.wait_cnt = 40'(ELECT_WAIT_CYC - 1);
            end else if (elect_now) begin
               nxt_st.el_state = EL_ELECT;
               nxt_st.el_idx = '0;
            end
         end
         EL_WAIT: begin
            // A new deployment restarts the wait; a peer route change does not wait
            if (start_wait) begin
               nxt_st.wait_cnt = 40'(ELECT_WAIT_CYC - 1);
            end else if (elect_now) begin
               nxt_st.el_state = EL_ELECT;
               nxt_st.el_idx = '0;
            end else if (st_ff.wait_cnt == 40'h00_0000_0000) begin
               nxt_st.el_state = EL_ELECT;
               nxt_st.el_idx = '0;
            end else begin
               nxt_st.wait_cnt = st_ff.wait_cnt - 40'h00_0000_0001;
            end
         end
         EL_ELECT: begin
            // Mid-sweep triggers are held; an immediate one cancels a pending wait
            if (elect_now) begin
               nxt_st.pend_el = 1'b1;
               nxt_st.pend_wait = 1'b0;
            end
            if (start_wait) begin
               nxt_st.pend_wait = 1'b1;
            end
            if (!st_ff.seg_up[st_ff.el_idx] || !st_ff.deployed[st_ff.el_idx]) begin
               nxt_st.flooder[st_ff.el_idx] = 1'b0;
            end else if (!sw_peer) begin
               nxt_st.flooder[st_ff.el_idx] = 1'b1;
            end else if (!sw_lb) begin
               // Keep a standing flooder; the lower address wins only for a fresh pick
               if (!st_ff.flooder[st_ff.el_idx]) begin
                  nxt_st.flooder[st_ff.el_idx] = (st_ff.own_ip < st_ff.peer_ip);
               end
            end else begin
               // Eligible here; the VLAN of each frame settles the choice at transmit
               nxt_st.flooder[st_ff.el_idx] = 1'b1;
            end
            if (st_ff.el_idx == CID_W'(NUM_CLIENTS - 1)) begin
               nxt_st.elect_count = st_ff.elect_count + 32'h0000_0001;
               if (nxt_st.pend_el) begin
                  nxt_st.pend_el = 1'b0;
                  nxt_st.el_idx = '0;
               end else if (nxt_st.pend_wait) begin
                  nxt_st.pend_wait = 1'b0;
                  nxt_st.el_state = EL_WAIT;
                  nxt_st.wait_cnt = 40'(ELECT_WAIT_CYC - 1);
               end else begin
                  nxt_st.el_state = EL_IDLE;
               end
            end else begin
               nxt_st.el_idx = st_ff.el_idx + CID_W'(1);
            end
         end
         default: nxt_st.el_state = EL_IDLE;
      endcase

      // ----------------------------------------------------------------
      // Transmit header build
      // ----------------------------------------------------------------
      // Local traffic carries no header and never reaches the peer link
      nxt_st.hdr_v = tx_valid && tx_to_peer;
      nxt_st.local_v = tx_valid && !tx_to_peer;
      nxt_st.w0 = {2'b00, 1'b0, 1'b0, 6'h00, HDR_LENGTH, 4'h0, HDR_MD_TYPE,
                   HDR_NEXT_PROTO};
      nxt_st.w1 = {4'h0, tx_vlan, HDR_SVC_INDEX, 8'h00};
      // Tag field is 15 bits, so the edge-port reserved value fits whole
      nxt_st.w2 = {tx_multi,
                   tx_from_client ? TAG_W'(tx_client_id) : TAG_EDGE_PORT,
                   16'h0000};
      vlan_ok = !st_ff.el_lb || elect_own;
      nxt_st.flood_cl = tx_valid && tx_multi && tx_from_client
                        && st_ff.flooder[tx_client_id] && vlan_ok;

      // ----------------------------------------------------------------
      // Receive path
      // ----------------------------------------------------------------
      // A header of the wrong metadata type is dropped, never delivered
      hdr_ok = rx_valid && rx_hdr_present && (rx_hdr_word0[11:8] == HDR_MD_TYPE);
      nxt_st.rxf_v = hdr_ok && rx_hdr_word2[31];
      nxt_st.rx_tag = rx_hdr_word2[30:16];
      // No client owns the edge-port tag, so nothing is suppressed for it
      nxt_st.rx_sup = hdr_ok && rx_hdr_word2[31]
                      && (rx_hdr_word2[30:16] != TAG_EDGE_PORT);
      nxt_st.rx_l2 = hdr_ok && !rx_hdr_word2[31];
      nxt_st.rx_drop = rx_valid && !hdr_ok;
   end

   // One register for all state: reset clears tables, timer and outputs together
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata = st_ff.rdata;
   // Decoded from the request so a new access is held off in its first cycle
   assign avs_waitrequest = (avs_read || avs_write) && !st_ff.wait_n;
   assign tx_hdr_valid = st_ff.hdr_v;
   assign tx_hdr_word0 = st_ff.w0;
   assign tx_hdr_word1 = st_ff.w1;
   assign tx_hdr_word2 = st_ff.w2;
   assign tx_flood_client = st_ff.flood_cl;
   assign tx_local_valid = st_ff.local_v;
   assign rx_flood_valid = st_ff.rxf_v;
   assign rx_suppress_tag = st_ff.rx_tag;
   assign rx_suppress_en = st_ff.rx_sup;
   assign rx_l2_valid = st_ff.rx_l2;
   assign rx_learn_en = 1'b0;
   assign rx_drop = st_ff.rx_drop;
endmodule : plh_encap

// ===== tb/plh_encap_sva.sv
/*
 Checker for plh_encap: transmit header fields and the receive dispatch.
 Assumes one clock domain and outputs that answer one cycle after a request.
*/
`timescale 1ns/1ps
module plh_encap_sva
   import plh_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic tx_valid,
   input wire logic [11:0] tx_vlan,
   input wire logic tx_from_client,
   input wire logic [plh_pkg::CID_W-1:0] tx_client_id,
   input wire logic tx_multi,
   input wire logic tx_to_peer,
   input wire logic tx_hdr_valid,
   input wire logic [31:0] tx_hdr_word0,
   input wire logic [31:0] tx_hdr_word1,
   input wire logic [31:0] tx_hdr_word2,
   input wire logic tx_flood_client,
   input wire logic tx_local_valid,
   input wire logic rx_valid,
   input wire logic rx_hdr_present,
   input wire logic [31:0] rx_hdr_word0,
   input wire logic [31:0] rx_hdr_word2,
   input wire logic rx_flood_valid,
   input wire logic [plh_pkg::TAG_W-1:0] rx_suppress_tag,
   input wire logic rx_l2_valid,
   input wire logic rx_learn_en,
   input wire logic rx_drop
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   hdr_follow_a: assert property (tx_valid && tx_to_peer |=> tx_hdr_valid && !tx_local_valid)
      else $error("header missing after peer descriptor");
   hdr_cause_a: assert property (tx_hdr_valid |-> $past(tx_valid && tx_to_peer))
      else $error("header without peer descriptor");
   local_only_a: assert property (tx_valid && !tx_to_peer |=> tx_local_valid && !tx_hdr_valid)
      else $error("local frame got a header");
   md_type_a: assert property (tx_hdr_valid |-> tx_hdr_word0[11:8] == 4'h1)
      else $error("metadata type wrong");
   vlan_keep_a: assert property (tx_valid && tx_to_peer |=>
      tx_hdr_word1[31:16] == {4'h0, $past(tx_vlan)})
      else $error("bridge domain differs from vlan");
   tag_pick_a: assert property (tx_valid && tx_to_peer |=> tx_hdr_word2[31:16] ==
      {$past(tx_multi), $past(tx_from_client) ? {6'h00, $past(tx_client_id)} : TAG_EDGE_PORT})
      else $error("source tag or multi flag wrong");
   flood_cause_a: assert property (tx_flood_client |-> $past(tx_valid && tx_multi && tx_from_client))
      else $error("client flood without client multicast");
   rx_flood_a: assert property (rx_valid && rx_hdr_present && rx_hdr_word2[31] &&
      rx_hdr_word0[11:8] == 4'h1 |=> rx_flood_valid && rx_suppress_tag == $past(rx_hdr_word2[30:16]))
      else $error("received flood not tagged");
   rx_uni_a: assert property (rx_valid && rx_hdr_present && !rx_hdr_word2[31] &&
      rx_hdr_word0[11:8] == 4'h1 |=> rx_l2_valid && !rx_flood_valid)
      else $error("received unicast not forwarded");
   rx_drop_a: assert property (rx_valid && !rx_hdr_present |=> rx_drop && !rx_l2_valid && !rx_flood_valid)
      else $error("headerless frame accepted");
   no_learn_a: assert property (!rx_learn_en)
      else $error("learning enabled on peer link");
endmodule : plh_encap_sva

bind plh_encap plh_encap_sva u_sva (.clk, .rstn, .tx_valid, .tx_vlan, .tx_from_client, .tx_client_id,
   .tx_multi, .tx_to_peer, .tx_hdr_valid, .tx_hdr_word0, .tx_hdr_word1, .tx_hdr_word2,
   .tx_flood_client, .tx_local_valid, .rx_valid, .rx_hdr_present, .rx_hdr_word0, .rx_hdr_word2,
   .rx_flood_valid, .rx_suppress_tag, .rx_l2_valid, .rx_learn_en, .rx_drop);

// ===== tb/plh_peer_mdl.sv
/*
 Peer switch model: sends peer-link frames on request and counts the
 well-formed headers it receives. Assumes the bench calls push.
*/
`timescale 1ns/1ps
module plh_peer_mdl (
   input wire logic clk,
   output logic rx_valid,
   output logic rx_hdr_present,
   output logic [31:0] rx_hdr_word0,
   output logic [31:0] rx_hdr_word2,
   input wire logic tx_hdr_valid,
   input wire logic [31:0] tx_hdr_word0,
   output int hdr_cnt
);
   logic busy = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_hdr_present = 1'b0;
      rx_hdr_word0 = 32'h0000_0000;
      rx_hdr_word2 = 32'h0000_0000;
      hdr_cnt = 0;
   end
   // Idle words keep toggling so a stale header never looks valid
   always @(posedge clk) begin
      if (!busy && !rx_valid) begin
         rx_hdr_word0 <= ~rx_hdr_word0;
         rx_hdr_word2 <= ~rx_hdr_word2;
      end
      if (tx_hdr_valid === 1'b1 && tx_hdr_word0[11:8] === 4'h1) begin
         hdr_cnt <= hdr_cnt + 1;
      end
   end
   task automatic push(input logic h, input logic [3:0] md, input logic m, input logic [14:0] tag);
      busy = 1'b1;
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_hdr_present <= h;
      rx_hdr_word0 <= {20'h0_0000, md, 8'h03};
      rx_hdr_word2 <= {m, tag, 16'h0000};
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_hdr_present <= 1'b0;
      busy = 1'b0;
   endtask : push
endmodule : plh_peer_mdl

// ===== tb/tb.sv
/*
 Testbench for plh_encap: registers, transmit headers, receive path, election.
 Assumes a 250 MHz clock and the peer model on the receive side.
*/
`timescale 1ns/1ps
module tb;
   import plh_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, q, tx_hdr_word0, tx_hdr_word1, tx_hdr_word2, rx_hdr_word0, rx_hdr_word2;
   logic avs_waitrequest, tx_hdr_valid, tx_flood_client, tx_local_valid, rx_valid, rx_hdr_present;
   logic rx_flood_valid, rx_suppress_en, rx_l2_valid, rx_learn_en, rx_drop, f3, f4;
   logic tx_valid = 1'b0;
   logic tx_from_client = 1'b0;
   logic tx_multi = 1'b0;
   logic tx_to_peer = 1'b0;
   logic [11:0] tx_vlan = 12'h000;
   logic [CID_W-1:0] tx_client_id = 9'h000;
   logic [TAG_W-1:0] rx_suppress_tag;
   int n_mismatch = 0;
   int n_tests = 0;
   int tx_hdrs;
   always #2 clk = ~clk;
   plh_encap DUT (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .tx_valid, .tx_vlan, .tx_from_client, .tx_client_id, .tx_multi, .tx_to_peer,
      .tx_hdr_valid, .tx_hdr_word0, .tx_hdr_word1, .tx_hdr_word2, .tx_flood_client, .tx_local_valid,
      .rx_valid, .rx_hdr_present, .rx_hdr_word0, .rx_hdr_word2, .rx_flood_valid, .rx_suppress_tag,
      .rx_suppress_en, .rx_l2_valid, .rx_learn_en, .rx_drop);
   plh_peer_mdl u_peer (.clk, .rx_valid, .rx_hdr_present, .rx_hdr_word0, .rx_hdr_word2,
      .tx_hdr_valid, .tx_hdr_word0, .hdr_cnt(tx_hdrs));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      {avs_address, avs_write, avs_read, avs_writedata} <= {a, wr, ~wr, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      {avs_read, avs_write} <= 2'b00;
      if (i == 20) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : bus
   task automatic tx(input logic [11:0] v, input logic fc, input logic [8:0] c, input logic m,
      input logic tp);
      @(posedge clk);
      {tx_valid, tx_vlan, tx_from_client, tx_client_id, tx_multi, tx_to_peer} <= {1'b1, v, fc, c, m, tp};
      @(posedge clk);
      tx_valid <= 1'b0;
      #1;
      chk("hdr_valid", tx_hdr_valid, tp);
      chk("local_valid", tx_local_valid, !tp);
      if (tp) begin
         chk("md_type", tx_hdr_word0[11:8], 4'h1);
         chk("bridge_domain", tx_hdr_word1[31:16], {4'h0, v});
         chk("multi_flag", tx_hdr_word2[31], m);
         chk("source_tag", tx_hdr_word2[30:16], fc ? {6'h00, c} : TAG_EDGE_PORT);
      end
   endtask : tx
   task automatic rx(input logic h, input logic [3:0] md, input logic m, input logic [14:0] tag);
      u_peer.push(h, md, m, tag);
      #1;
      chk("rx_flood", rx_flood_valid, h && md == 4'h1 && m);
      chk("rx_l2", rx_l2_valid, h && md == 4'h1 && !m);
      chk("rx_drop", rx_drop, !h || md != 4'h1);
      chk("rx_learn", rx_learn_en, 1'b0);
      if (h && m && md == 4'h1) begin
         chk("rx_tag", rx_suppress_tag, tag);
         chk("rx_suppress", rx_suppress_en, tag != TAG_EDGE_PORT);
      end
   endtask : rx
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      bus(1'b0, REG_CTRL, 32'h0000_0000);
      chk("ctrl_reset", q, RESET_WORD);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      chk("status_reset", q, {30'h0, EL_IDLE});
      bus(1'b1, 8'h40, 32'h1234_5678);
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", q, UNMAPPED_WORD);
      $display("test registers done");
   endtask : t_regs
   task automatic t_tx;
      tx(12'h005, 1'b0, 9'h000, 1'b1, 1'b1);
      tx(12'h005, 1'b1, 9'h00a, 1'b1, 1'b1);
      tx(12'hfff, 1'b1, 9'h1ff, 1'b0, 1'b1);
      tx(12'h064, 1'b0, 9'h000, 1'b0, 1'b1);
      tx(12'h007, 1'b1, 9'h003, 1'b0, 1'b0);
      chk("peer_headers", tx_hdrs, 32'h0000_0004);
      $display("test transmit done");
   endtask : t_tx
   task automatic t_rx;
      rx(1'b1, 4'h1, 1'b1, 15'h000a);
      rx(1'b1, 4'h1, 1'b1, TAG_EDGE_PORT);
      rx(1'b1, 4'h1, 1'b0, 15'h0014);
      rx(1'b0, 4'h1, 1'b0, 15'h0000);
      rx(1'b1, 4'h2, 1'b1, 15'h0005);
      $display("test receive done");
   endtask : t_rx
   task automatic t_elect;
      bus(1'b1, REG_OWN_IP, 32'h0a00_0002);
      bus(1'b1, REG_PEER_IP, 32'h0a00_0001);
      bus(1'b1, REG_CTRL, 32'h0000_0003);
      bus(1'b1, REG_TAB_ADDR, 32'h0000_000a);
      bus(1'b1, REG_TAB_DATA, 32'h0000_0003);
      bus(1'b1, REG_TRIGGER, 32'h0000_0002);
      // Triggers landing in the first sweep queue a second full sweep
      repeat (1200) @(posedge clk);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      chk("status_done", q, {30'h0, EL_IDLE});
      tx(12'h003, 1'b1, 9'h00a, 1'b1, 1'b1);
      chk("flood_odd_vlan", tx_flood_client, 1'b1);
      tx(12'h004, 1'b1, 9'h00a, 1'b1, 1'b1);
      chk("flood_even_vlan", tx_flood_client, 1'b0);
      bus(1'b1, REG_CTRL, 32'h0000_0002);
      bus(1'b1, REG_TRIGGER, 32'h0000_0002);
      repeat (600) @(posedge clk);
      tx(12'h003, 1'b1, 9'h00a, 1'b1, 1'b1);
      f3 = tx_flood_client;
      tx(12'h004, 1'b1, 9'h00a, 1'b1, 1'b1);
      f4 = tx_flood_client;
      chk("standing_flooder", f3, 1'b1);
      chk("single_flooder", f4, f3);
      bus(1'b1, REG_TRIGGER, 32'h0000_0001);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      chk("status_wait", q, {30'h0, EL_WAIT});
      tx(12'h003, 1'b1, 9'h00a, 1'b1, 1'b1);
      chk("flooder_held", tx_flood_client, f3);
      $display("test election done");
   endtask : t_elect
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      t_elect();
      wrap_up();
   end
endmodule : tb
